// ==== bench/dbl_ctl_model.sv ====
`timescale 1ns/1ps
// Behavioural memory controller that drives one command per clock.
module dbl_ctl_model
  import dbl_pkg::*;
(
  input wire logic i_sys_clk, // System clock.
  output logic o_cs_n, // Chip select, active low.
  output logic o_ras_n, // Row strobe, active low.
  output logic o_cas_n, // Column strobe, active low.
  output logic o_we_n, // Write enable, active low.
  output logic [DBL_BA_W-1:0] o_ba, // Bank address.
  output logic [DBL_ADDR_W-1:0] o_addr // Address.
);
  // The pins start deselected so reset sees no command.
  initial begin
    o_cs_n = 1'b1;
    {o_ras_n, o_cas_n, o_we_n} = 3'h7;
    o_ba = '0;
    o_addr = '0;
  end
  function automatic logic [2:0] strobes(input dbl_cmd_t c);
    case (c)
      DBL_C_READ: return 3'h5;
      DBL_C_WRITE: return 3'h4;
      DBL_C_ACT: return 3'h3;
      DBL_C_PRE: return 3'h2;
      DBL_C_REF: return 3'h1;
      DBL_C_MRS: return 3'h0;
      default: return 3'h7;
    endcase
  endfunction
  // the caller picks legal and illegal commands alike.
  // Unused address bits toggle so the device cannot lean on them.
  task automatic send(input dbl_cmd_t c, input logic [2:0] ba,
                      input logic a10);
    @(posedge i_sys_clk);
    o_cs_n <= 1'b0;
    {o_ras_n, o_cas_n, o_we_n} <= strobes(c);
    o_ba <= ba;
    o_addr <= {~o_addr[13:11], a10, ~o_addr[9:0]};
  endtask
  // deselect leaves junk on every other pin.
  task automatic deselect();
    @(posedge i_sys_clk);
    o_cs_n <= 1'b1;
    {o_ras_n, o_cas_n, o_we_n} <= ~{o_ras_n, o_cas_n, o_we_n};
    o_ba <= ~o_ba;
    o_addr <= ~o_addr;
  endtask
endmodule

// ==== bench/ddr2_bank_command_legality_test.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error %0t: got %0h expected %0h", $time, g, e); end end
// Self-checking bench for the command legality checker.
module ddr2_bank_command_legality_test;
  import dbl_pkg::*;
  localparam logic [1:0] ACC = 2'h1; // Accept pulse expected.
  localparam logic [1:0] ILL = 2'h2; // Illegal pulse expected.
  logic i_sys_clk = 1'b0; // System clock.
  logic i_rst_n = 1'b0; // Reset, active low.
  logic cs_n, ras_n, cas_n, we_n; // Command pins.
  logic [DBL_BA_W-1:0] ba; // Bank address.
  logic [DBL_ADDR_W-1:0] addr; // Address.
  logic o_illegal, o_accept, o_all_idle; // Device answers.
  logic [DBL_BANKS-1:0] o_bank_busy; // Busy per bank.
  logic [2:0] cur = 3'h0; // Check flag, illegal, accept of this cycle.
  logic [2:0] pipe [3] = '{default: 3'h0}; // Expectations in flight.
  int n_mismatch = 0;
  int total_checks = 0;
  // Free running clock of 50 ns.
  initial forever #25 i_sys_clk = ~i_sys_clk;
  dbl_ctl_model ctl (.i_sys_clk(i_sys_clk), .o_cs_n(cs_n), .o_ras_n(ras_n),
    .o_cas_n(cas_n), .o_we_n(we_n), .o_ba(ba), .o_addr(addr));
  dbl_cmd_check dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
    .i_cs_n(cs_n), .i_ras_n(ras_n), .i_cas_n(cas_n), .i_we_n(we_n),
    .i_ba(ba), .i_addr(addr), .o_illegal(o_illegal), .o_accept(o_accept),
    .o_all_idle(o_all_idle), .o_bank_busy(o_bank_busy));
  // The answer pulse is registered on the third edge after the pins
  // change, so each expectation rides a three deep pipe.
  always @(posedge i_sys_clk) begin
    pipe[0] <= cur;
    pipe[1] <= pipe[0];
    pipe[2] <= pipe[1];
    #1;
    if (pipe[2][2] === 1'b1) begin
      `CHK({o_illegal, o_accept}, pipe[2][1:0])
    end
  end
  // One command this cycle with its expected answer.
  task automatic cmd(input dbl_cmd_t c, input logic [2:0] b,
                     input logic a10, input logic [1:0] e);
    ctl.send(c, b, a10);
    cur <= {1'b1, e};
  endtask
  // Deselect cycles, which must answer nothing.
  task automatic nop(input int n);
    repeat (n) begin
      ctl.deselect();
      cur <= 3'h4;
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // A hang is cut short here and counted.
  initial begin
    repeat (3000) @(posedge i_sys_clk);
    n_mismatch++;
    $display("Error %0t: run too long", $time);
    print_verdict();
  end
  // Refresh locks out every bank until its cycle time is over.
  task automatic t_refresh();
    cmd(DBL_C_REF, 3'h0, 1'b0, ACC);
    cmd(DBL_C_ACT, 3'h1, 1'b0, ILL);
    nop(2);
    #1 `CHK(o_all_idle, 1'b0)
    nop(4);
    cmd(DBL_C_ACT, 3'h1, 1'b0, ACC);
    nop(3);
    cmd(DBL_C_PRE, 3'h1, 1'b0, ACC);
    cmd(DBL_C_NOP, 3'h3, 1'b0, 2'h0);
    nop(4);
    $display("test refresh done");
  endtask
  // Mode set blocks all banks; activating refuses a second activate.
  task automatic t_mrs();
    cmd(DBL_C_MRS, 3'h0, 1'b0, ACC);
    cmd(DBL_C_ACT, 3'h2, 1'b0, ILL);
    nop(4);
    cmd(DBL_C_ACT, 3'h2, 1'b0, ACC);
    cmd(DBL_C_ACT, 3'h2, 1'b0, ILL);
    nop(3);
    cmd(DBL_C_PRE, 3'h5, 1'b1, ACC);
    cmd(DBL_C_PRE, 3'h2, 1'b0, ACC);
    nop(3);
    $display("test mode set done");
  endtask
  // Read with auto-precharge locks its bank only.
  task automatic t_read_ap();
    cmd(DBL_C_ACT, 3'h0, 1'b0, ACC);
    nop(2);
    cmd(DBL_C_REF, 3'h0, 1'b0, ILL);
    cmd(DBL_C_READ, 3'h0, 1'b1, ACC);
    cmd(DBL_C_WRITE, 3'h0, 1'b0, ILL);
    cmd(DBL_C_ACT, 3'h0, 1'b0, ILL);
    cmd(DBL_C_PRE, 3'h2, 1'b1, ILL);
    cmd(DBL_C_ACT, 3'h4, 1'b0, ACC);
    #1 `CHK(o_bank_busy, 8'h01)
    nop(8);
    #1 `CHK(o_bank_busy, 8'h00)
    cmd(DBL_C_ACT, 3'h0, 1'b0, ACC);
    nop(3);
    $display("test read auto done");
  endtask
  // Write with auto-precharge, writes to the other bank meanwhile.
  task automatic t_write_ap();
    cmd(DBL_C_WRITE, 3'h4, 1'b1, ACC);
    cmd(DBL_C_READ, 3'h4, 1'b0, ILL);
    cmd(DBL_C_MRS, 3'h0, 1'b0, ILL);
    cmd(DBL_C_WRITE, 3'h0, 1'b0, ACC);
    cmd(DBL_C_WRITE, 3'h0, 1'b0, ACC);
    cmd(DBL_C_WRITE, 3'h4, 1'b0, ILL);
    nop(7);
    cmd(DBL_C_ACT, 3'h4, 1'b0, ACC);
    nop(3);
    cmd(DBL_C_PRE, 3'h0, 1'b1, ACC);
    nop(6);
    #1 `CHK(o_all_idle, 1'b1)
    $display("test write auto done");
  endtask
  // Main sequence: reset for 20 clocks, then each scenario.
  initial begin
    repeat (19) @(posedge i_sys_clk);
    #1 `CHK({o_illegal, o_accept, o_all_idle, o_bank_busy}, 11'h0)
    @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    nop(6);
    #1 `CHK(o_all_idle, 1'b1)
    t_refresh();
    t_mrs();
    t_read_ap();
    t_write_ap();
    nop(3);
    print_verdict();
  end
endmodule

// ==== logic/dbl_bank.sv ====
`timescale 1ns/1ps
// One bank's state and countdown timer.
module dbl_bank
  import dbl_pkg::*;
(
  input wire logic i_sys_clk, // System clock.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_hit, // Legal command addressed to this bank.
  input wire dbl_cmd_t i_cmd, // Decoded command.
  input wire logic i_ap, // Auto-precharge flag of the command.
  output dbl_bank_t o_state, // Current state.
  output logic o_busy // Transient state, timer running.
);
  typedef struct packed {
    dbl_bank_t st;
    logic [DBL_TMR_W-1:0] tmr;
    logic wr;
  } dbl_bs_t;
  dbl_bs_t s_r;
  dbl_bs_t s_nxt;

  // Time expires when the counter reaches one.
  logic done;
  assign done = (s_r.tmr <= 4'h1);
  assign o_state = s_r.st;
  assign o_busy = (s_r.st != DBL_IDLE) && (s_r.st != DBL_ACTIVE);

  // Next state from the current state and any accepted command.
  always_comb begin
    s_nxt = s_r;
    if (s_r.tmr != 4'h0) begin
      s_nxt.tmr = s_r.tmr - 4'h1;
    end
    unique case (s_r.st)
      DBL_IDLE: begin
        if (i_hit && i_cmd == DBL_C_ACT) begin
          s_nxt.st = DBL_ACTIVATING;
          s_nxt.tmr = DBL_TMR_W'(DBL_TRCD_CK);
        end
      end
      // R4 row active after delay
      DBL_ACTIVATING: begin
        if (done) begin
          s_nxt.st = DBL_ACTIVE;
        end
      end
      DBL_ACTIVE: begin
        if (i_hit && i_cmd == DBL_C_PRE) begin
          s_nxt.st = DBL_PRECHARGING;
          s_nxt.tmr = DBL_TMR_W'(DBL_TRP_CK);
        end else if (i_hit && (i_cmd == DBL_C_WRITE ||
                               i_cmd == DBL_C_READ)) begin
          s_nxt.wr = (i_cmd == DBL_C_WRITE);
          // A plain burst ends in write recovery or stays active.
          s_nxt.st = i_ap ? DBL_BURST_AP :
                     (i_cmd == DBL_C_WRITE ? DBL_WREC : DBL_ACTIVE);
          s_nxt.tmr = DBL_TMR_W'(i_ap ? DBL_BL_CK : DBL_TWR_CK);
        end
      end
      // R1 burst runs to end
      DBL_BURST_AP: begin
        if (done) begin
          s_nxt.st = s_r.wr ? DBL_WREC_AP : DBL_PRECHARGING;
          s_nxt.tmr = DBL_TMR_W'(s_r.wr ? DBL_TWR_CK : DBL_TRP_CK);
        end
      end
      // R5 new write restarts recovery
      DBL_WREC: begin
        if (i_hit && i_cmd == DBL_C_WRITE) begin
          s_nxt.st = i_ap ? DBL_BURST_AP : DBL_WREC;
          s_nxt.wr = 1'b1;
          s_nxt.tmr = DBL_TMR_W'(i_ap ? DBL_BL_CK : DBL_TWR_CK);
        end else if (done) begin
          s_nxt.st = DBL_ACTIVE;
        end
      end
      // R6 precharge after recovery
      DBL_WREC_AP: begin
        if (done) begin
          s_nxt.st = DBL_PRECHARGING;
          s_nxt.tmr = DBL_TMR_W'(DBL_TRP_CK);
        end
      end
      // R3 idle after precharge time
      DBL_PRECHARGING: begin
        if (done) begin
          s_nxt.st = DBL_IDLE;
        end
      end
      default: begin
        s_nxt.st = DBL_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // R3 precharge ends in time
  AST_PRE_TO_IDLE: assert property (@(posedge i_sys_clk) // R3
    disable iff (!i_rst_n)
    $rose(s_r.st == DBL_PRECHARGING) |-> ##1 (s_r.st == DBL_IDLE))
    else $error("Precharge did not end after its time.");
  // R4 activation ends in time
  AST_ACT_TO_ACTIVE: assert property (@(posedge i_sys_clk) // R4
    disable iff (!i_rst_n)
    $rose(s_r.st == DBL_ACTIVATING) |-> ##1 (s_r.st == DBL_ACTIVE))
    else $error("Activation did not end after its time.");
  // R6 recovery then precharge
  AST_WRAP_TO_PRE: assert property (@(posedge i_sys_clk) // R6
    disable iff (!i_rst_n)
    (s_r.st == DBL_WREC_AP) |=> (s_r.st == DBL_PRECHARGING))
    else $error("Recovery with precharge did not precharge.");
endmodule

// ==== logic/dbl_cmd_check.sv ====
`timescale 1ns/1ps
// Command legality checker and per bank state keeper.
// Notes on behaviour
// R1 - auto-precharge burst: only deselect or no-op
// R2 - other banks may take permitted commands
// R3 - precharging bank idles after precharge time
// R4 - activating bank becomes active after delay
// R5 - write recovery accepts new write only
// R6 - recovery with precharge then precharges
// R7 - refresh blocks every command until done
// R8 - mode register set blocks every command
// R9 - no burst interrupt at length four; only auto-precharge bursts are timed, plain ones may be cut next clock
// R10 - read by read, write by write
// R11 - refresh and mode set need idle
// R12 - chip select high means deselect
// R13 - decode strobes; address ten selects auto
// R14 - independent state and timer per bank
module dbl_cmd_check
  import dbl_pkg::*;
(
  input wire logic i_sys_clk, // System clock, 20 MHz.
  input wire logic i_rst_n, // Synchronous reset, active low.
  input wire logic i_cs_n, // Chip select, active low.
  input wire logic i_ras_n, // Row strobe, active low.
  input wire logic i_cas_n, // Column strobe, active low.
  input wire logic i_we_n, // Write enable, active low.
  input wire logic [DBL_BA_W-1:0] i_ba, // Bank address.
  input wire logic [DBL_ADDR_W-1:0] i_addr, // Address.
  output logic o_illegal, // Pulse: last command was illegal.
  output logic o_accept, // Pulse: last command was taken.
  output logic o_all_idle, // All banks idle, no device wait.
  output logic [DBL_BANKS-1:0] o_bank_busy // Per bank transient state.
);
  // Pins pass two flip-flops before any logic reads them.
  typedef struct packed {
    logic [3:0] p1;
    logic [3:0] p2;
    logic [DBL_BA_W-1:0] b1;
    logic [DBL_BA_W-1:0] b2;
    logic a1;
    logic a2;
    logic [DBL_TMR_W-1:0] glob;
    logic illegal;
    logic accept;
    logic all_idle;
    logic [DBL_BANKS-1:0] busy;
  } dbl_st_t;
  dbl_st_t s_r;
  dbl_st_t s_nxt;

  dbl_cmd_t cmd;
  logic [DBL_BANKS-1:0] hit;
  logic [DBL_BANKS-1:0] idle;
  logic [DBL_BANKS-1:0] bbusy;
  dbl_bank_t st [DBL_BANKS];
  logic legal;
  logic ap;
  dbl_bank_t tgt;

  // R13 command decode
  always_comb begin
    cmd = DBL_C_NOP;
    // R12 chip select high ignored
    if (!s_r.p2[3]) begin
      unique case (s_r.p2[2:0])
        3'h7: cmd = DBL_C_NOP;
        3'h5: cmd = DBL_C_READ;
        3'h4: cmd = DBL_C_WRITE;
        3'h3: cmd = DBL_C_ACT;
        3'h2: cmd = DBL_C_PRE;
        3'h1: cmd = DBL_C_REF;
        3'h0: cmd = DBL_C_MRS;
        default: cmd = DBL_C_NOP;
      endcase
    end
  end
  assign ap = s_r.a2;
  assign tgt = st[s_r.b2];

  // Legality of the decoded command against bank and device state.
  always_comb begin
    legal = 1'b1;
    if (cmd != DBL_C_NOP) begin
      // R7 R8 device wait blocks all
      if (s_r.glob != 4'h0) begin
        legal = 1'b0;
      end else if (cmd == DBL_C_REF || cmd == DBL_C_MRS) begin
        // R11 needs all idle
        legal = &idle;
      end else if (cmd == DBL_C_PRE && ap) begin
        // Precharge-all must not disturb a bank in a locked state.
        for (int i = 0; i < DBL_BANKS; i++) begin
          if (!(st[i] == DBL_IDLE || st[i] == DBL_ACTIVE ||
                st[i] == DBL_PRECHARGING)) begin
            legal = 1'b0;
          end
        end
      end else begin
        // R2 R14 judged per target bank
        unique case (tgt)
          DBL_IDLE: legal = (cmd == DBL_C_ACT) || (cmd == DBL_C_PRE);
          DBL_ACTIVE: legal = (cmd != DBL_C_ACT);
          // R3 repeated precharge is a no-op
          DBL_PRECHARGING: legal = (cmd == DBL_C_PRE);
          // R5 only a new write
          DBL_WREC: legal = (cmd == DBL_C_WRITE);
          // R1 R4 R6 locked states
          default: legal = 1'b0;
        endcase
      end
    end
  end

  // R14 one bank per instance
  generate
    for (genvar g = 0; g < DBL_BANKS; g++) begin : g_bank
      assign hit[g] = legal && (cmd == DBL_C_PRE ?
        (ap || s_r.b2 == DBL_BA_W'(g)) : (s_r.b2 == DBL_BA_W'(g)));
      assign idle[g] = (st[g] == DBL_IDLE);
      dbl_bank u_bank (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_hit(hit[g]),
        .i_cmd(cmd),
        .i_ap(ap),
        .o_state(st[g]),
        .o_busy(bbusy[g])
      );
    end
  endgenerate

  // Next values of the synchronisers, device timer and outputs.
  always_comb begin
    s_nxt = s_r;
    s_nxt.p1 = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    s_nxt.p2 = s_r.p1;
    s_nxt.b1 = i_ba;
    s_nxt.b2 = s_r.b1;
    s_nxt.a1 = i_addr[DBL_AP_BIT];
    s_nxt.a2 = s_r.a1;
    if (s_r.glob != 4'h0) begin
      s_nxt.glob = s_r.glob - 4'h1;
    end
    // R7 refresh cycle wait
    if (legal && cmd == DBL_C_REF) begin
      s_nxt.glob = DBL_TMR_W'(DBL_TRFC_CK);
    end
    // R8 mode register wait
    if (legal && cmd == DBL_C_MRS) begin
      s_nxt.glob = DBL_TMR_W'(DBL_TMRD_CK);
    end
    s_nxt.illegal = !legal;
    s_nxt.accept = legal && (cmd != DBL_C_NOP);
    s_nxt.all_idle = (&idle) && (s_nxt.glob == 4'h0);
    s_nxt.busy = bbusy;
  end

  // Single state register.
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      s_r <= '0;
      s_r.p1 <= 4'hf;
      s_r.p2 <= 4'hf;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_illegal = s_r.illegal;
  assign o_accept = s_r.accept;
  assign o_all_idle = s_r.all_idle;
  assign o_bank_busy = s_r.busy;

  // R12 deselect answers nothing
  AST_CS_HIGH_NOP: assert property (@(posedge i_sys_clk) // R12
    disable iff (!i_rst_n)
    s_r.p2[3] |=> !s_r.illegal && !s_r.accept)
    else $error("Deselect was not treated as no-op.");
  // R7 refresh wait loaded
  AST_REF_BLOCKS: assert property (@(posedge i_sys_clk) // R7
    disable iff (!i_rst_n)
    (legal && cmd == DBL_C_REF) |=> (s_r.glob == 4'h3))
    else $error("Refresh wait not loaded.");
  // R8 mode set wait enforced
  AST_MRS_BLOCKS: assert property (@(posedge i_sys_clk) // R8
    disable iff (!i_rst_n)
    (legal && cmd == DBL_C_MRS) |=> ((s_r.glob == 4'h2) and
    ((cmd != DBL_C_NOP) |=> s_r.illegal)))
    else $error("Mode set wait not enforced.");
  // R11 refresh needs idle
  AST_REF_NEEDS_IDLE: assert property (@(posedge i_sys_clk) // R11
    disable iff (!i_rst_n)
    (cmd == DBL_C_REF && !(&idle)) |=> s_r.illegal)
    else $error("Refresh accepted with a bank open.");
  // R11 mode set needs idle
  AST_MRS_NEEDS_IDLE: assert property (@(posedge i_sys_clk) // R11
    disable iff (!i_rst_n)
    (cmd == DBL_C_MRS && !(&idle)) |=> s_r.illegal)
    else $error("Mode set accepted with a bank open.");
  // R1 burst bank locked
  AST_AP_LOCK: assert property (@(posedge i_sys_clk) // R1
    disable iff (!i_rst_n)
    (tgt == DBL_BURST_AP && cmd inside {DBL_C_READ, DBL_C_WRITE,
     DBL_C_ACT} ) |=> s_r.illegal)
    else $error("Command to auto-precharge burst bank taken.");
  // R5 new write accepted
  AST_WREC_WRITE: assert property (@(posedge i_sys_clk) // R5
    disable iff (!i_rst_n)
    (s_r.glob == 4'h0 && tgt == DBL_WREC && cmd == DBL_C_WRITE) |=>
    s_r.accept)
    else $error("New write during recovery refused.");
  // R3 repeated precharge harmless
  AST_PRE_REPEAT: assert property (@(posedge i_sys_clk) // R3
    disable iff (!i_rst_n)
    (s_r.glob == 4'h0 && tgt == DBL_PRECHARGING && cmd == DBL_C_PRE &&
     !ap) |=> s_r.accept)
    else $error("Repeated precharge was refused.");
  // R4 activating bank locked
  AST_ACT_LOCK: assert property (@(posedge i_sys_clk) // R4
    disable iff (!i_rst_n)
    (tgt == DBL_ACTIVATING && cmd != DBL_C_NOP) |=> s_r.illegal)
    else $error("Command to activating bank taken.");
  // R6 recovering bank locked
  AST_WRAP_LOCK: assert property (@(posedge i_sys_clk) // R6
    disable iff (!i_rst_n)
    (tgt == DBL_WREC_AP && cmd != DBL_C_NOP) |=> s_r.illegal)
    else $error("Command to recovering auto-precharge bank taken.");
endmodule

// ==== logic/dbl_pkg.sv ====
package dbl_pkg;
  // Bank count and address widths.
  localparam int unsigned DBL_BANKS = 8;
  localparam int unsigned DBL_BA_W = 3;
  localparam int unsigned DBL_AP_BIT = 10;
  localparam int unsigned DBL_ADDR_W = 14;
  // Clock period in picoseconds.
  localparam int unsigned DBL_TCK_PS = 50000;
  // Timing figures in picoseconds.
  localparam int unsigned DBL_TRP_PS = 15000;
  localparam int unsigned DBL_TRCD_PS = 15000;
  localparam int unsigned DBL_TWR_PS = 15000;
  localparam int unsigned DBL_TRFC_PS = 127500;
  // Burst and mode register delay in clocks.
  localparam int unsigned DBL_TMRD_CK = 2;
  localparam int unsigned DBL_BL_CK = 4;
  // Derived least counts, rounded up, at least one.
  localparam int unsigned DBL_TRP_CK =
    (DBL_TRP_PS + DBL_TCK_PS - 1) / DBL_TCK_PS;
  localparam int unsigned DBL_TRCD_CK =
    (DBL_TRCD_PS + DBL_TCK_PS - 1) / DBL_TCK_PS;
  localparam int unsigned DBL_TWR_CK =
    (DBL_TWR_PS + DBL_TCK_PS - 1) / DBL_TCK_PS;
  localparam int unsigned DBL_TRFC_CK =
    (DBL_TRFC_PS + DBL_TCK_PS - 1) / DBL_TCK_PS;
  localparam int unsigned DBL_TMR_W = 4;
  // Per bank state codes.
  typedef enum logic [2:0] {
    DBL_IDLE = 3'h0,
    DBL_ACTIVATING = 3'h1,
    DBL_ACTIVE = 3'h2,
    DBL_BURST_AP = 3'h3,
    DBL_WREC = 3'h4,
    DBL_WREC_AP = 3'h5,
    DBL_PRECHARGING = 3'h6
  } dbl_bank_t;
  // Decoded commands.
  typedef enum logic [2:0] {
    DBL_C_NOP = 3'h0,
    DBL_C_READ = 3'h1,
    DBL_C_WRITE = 3'h2,
    DBL_C_ACT = 3'h3,
    DBL_C_PRE = 3'h4,
    DBL_C_REF = 3'h5,
    DBL_C_MRS = 3'h6
  } dbl_cmd_t;
endpackage
